// >>> olsc_regs.svh
// olsc_regs.svh: offsets, field positions, reset value and table constants
// of the open-loop start-up configuration register.
// assumes: included by bare name from the design files that need it.
`ifndef OLSC_REGS_SVH
`define OLSC_REGS_SVH

`define OLSC_CFG_OFFSET    8'h84
`define OLSC_CFG_RESET     32'h0000_0000
`define OLSC_WR_MASK       32'hFFFF_FFFC
`define OLSC_PARITY_BIT    31
`define OLSC_SRC_BIT       30
`define OLSC_DUTY_MSB      29
`define OLSC_DUTY_LSB      27
`define OLSC_THR_MSB       26
`define OLSC_THR_LSB       23
`define OLSC_ACC1_MSB      22
`define OLSC_ACC1_LSB      18
`define OLSC_ACC2_MSB      17
`define OLSC_ACC2_LSB      13
`define OLSC_HOFF_MSB      12
`define OLSC_HOFF_LSB      8
`define OLSC_AUTO_BIT      7
`define OLSC_FCYC_BIT      6
`define OLSC_MDUTY_MSB     5
`define OLSC_MDUTY_LSB     2
`define OLSC_SENSE_STEP_MV 11'h064
`define OLSC_NO_LIMIT_CODE 5'h1F
`define OLSC_NO_LIMIT_RATE 25'h1F3FC18

`endif

// >>> olsc_pkg.sv
// olsc_pkg: types shared by the configuration register and its rate table.
// assumes: nothing beyond the header of constants.
package olsc_pkg;

  typedef logic [4:0]  olsc_code_t;
  // ramp rates carried in milli-hertz per second (or per second squared)
  typedef logic [24:0] olsc_rate_t;

  typedef struct packed {
    logic       parity;
    logic       src_runtime;
    logic [2:0] duty;
    logic [3:0] thresh;
    logic [4:0] acc1;
    logic [4:0] acc2;
    logic [4:0] handoff;
    logic       auto_handoff;
    logic       first_zero;
    logic [3:0] min_duty;
    logic [1:0] rsvd;
  } olsc_cfg_s;

endpackage : olsc_pkg

// >>> olsc_lut_if.sv
// olsc_lut_if: ramp-rate codes out to the rate table, rates back.
// assumes: both ends share one clock; index 0 first stage, 1 second stage.
`timescale 1ns/10ps
`default_nettype none
interface olsc_lut_if;
  olsc_pkg::olsc_code_t code [2];
  olsc_pkg::olsc_rate_t rate [2];
  modport req (output code, input rate);
  modport tab (input code, output rate);
endinterface : olsc_lut_if
`default_nettype wire

// >>> olsc_rate_lut.sv
// olsc_rate_lut: registered 32-entry ramp-rate table, one lane per stage.
// assumes: codes come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "olsc_regs.svh"
module olsc_rate_lut (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // table port
  olsc_lut_if.tab   lut
);

  function automatic olsc_pkg::olsc_rate_t rate_of(
    input olsc_pkg::olsc_code_t c);
    case (c)
      5'h00:   rate_of = 25'h0000005;
      5'h01:   rate_of = 25'h000000A;
      5'h02:   rate_of = 25'h0000019;
      5'h03:   rate_of = 25'h0000032;
      5'h04:   rate_of = 25'h0000064;
      5'h05:   rate_of = 25'h00000FA;
      5'h06:   rate_of = 25'h00001F4;
      5'h07:   rate_of = 25'h00003E8;
      5'h08:   rate_of = 25'h00009C4;
      5'h09:   rate_of = 25'h0001388;
      5'h0A:   rate_of = 25'h0001D4C;
      5'h0B:   rate_of = 25'h0002710;
      5'h0C:   rate_of = 25'h00030D4;
      5'h0D:   rate_of = 25'h0003A98;
      5'h0E:   rate_of = 25'h0004E20;
      5'h0F:   rate_of = 25'h0007530;
      5'h10:   rate_of = 25'h0009C40;
      5'h11:   rate_of = 25'h000C350;
      5'h12:   rate_of = 25'h000EA60;
      5'h13:   rate_of = 25'h00124F8;
      5'h14:   rate_of = 25'h00186A0;
      5'h15:   rate_of = 25'h001E848;
      5'h16:   rate_of = 25'h00249F0;
      5'h17:   rate_of = 25'h002AB98;
      5'h18:   rate_of = 25'h0030D40;
      5'h19:   rate_of = 25'h003D090;
      5'h1A:   rate_of = 25'h00493E0;
      5'h1B:   rate_of = 25'h0061A80;
      5'h1C:   rate_of = 25'h007A120;
      5'h1D:   rate_of = 25'h00B71B0;
      5'h1E:   rate_of = 25'h00F4240;
      // no-limit code maps to the internal ceiling
      default: rate_of = `OLSC_NO_LIMIT_RATE;
    endcase
  endfunction : rate_of

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_lane
      always_ff @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
          lut.rate[ch] <= 25'h0000005;
        else
          lut.rate[ch] <= rate_of(lut.code[ch]);
      end
    end
  endgenerate

  property p_first_slowest;
    @(posedge i_clk) disable iff (i_rst)
    lut.code[0] == 5'h00 |=> lut.rate[0] == 25'h0000005;
  endproperty
  a_first_slowest: assert property (p_first_slowest)
    else $error("first ramp code 0 did not give 5 mHz/s");

  property p_first_fastest;
    @(posedge i_clk) disable iff (i_rst)
    lut.code[0] == 5'h1E |=> lut.rate[0] == 25'h00F4240;
  endproperty
  a_first_fastest: assert property (p_first_fastest)
    else $error("first ramp code 1E did not give 1000 Hz/s");

  property p_first_nolimit;
    @(posedge i_clk) disable iff (i_rst)
    lut.code[0] == `OLSC_NO_LIMIT_CODE |=>
      lut.rate[0] == `OLSC_NO_LIMIT_RATE;
  endproperty
  a_first_nolimit: assert property (p_first_nolimit)
    else $error("first ramp no-limit code did not give ceiling");

  property p_second_ends;
    @(posedge i_clk) disable iff (i_rst)
    (lut.code[1] == 5'h00 |=> lut.rate[1] == 25'h0000005) and
    (lut.code[1] == 5'h1F |=> lut.rate[1] == `OLSC_NO_LIMIT_RATE);
  endproperty
  a_second_ends: assert property (p_second_ends)
    else $error("second ramp table end points wrong");

endmodule : olsc_rate_lut
`default_nettype wire

// >>> olsc_top.sv
// olsc_top: open-loop start-up configuration register and its decode.
// assumes: the register port is driven by configuration logic on i_clk;
// companion settings arrive on i_clk too, so nothing is synchronised.
//
// Overview of operation
// - one 32-bit start-up configuration register answers at address 84h.
// - bit 30 picks open-loop limit field (0) or run-time limit (1).
// - bits 29-27 cap duty: 10,15,20,25,30,40,50,100 percent.
// - bits 26-23 give code times 0.1 V; code 0 means not applicable.
// - bits 22-18 pick first ramp rate, 0.005 to 1000 Hz/s.
// - first ramp code 1Fh removes the limit, taken as 32767 Hz/s.
// - bits 17-13 pick second ramp term, 0.005 Hz/s2 to no limit.
// - bits 12-8 set loop transfer frequency, 1 Hz up to 600 Hz.
// - bit 7 set means automatic handoff, clear means use threshold.
// - bit 6 set starts first cycle at 0 Hz, else companion setting.
`timescale 1ns/10ps
`default_nettype none
`include "olsc_regs.svh"
module olsc_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // register port
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  output logic      [31:0]       o_rdata,
  output logic                   o_rd_valid,
  // companion settings
  input  wire logic [3:0]        i_runtime_current_limit,
  input  wire logic [3:0]        i_initial_cycle_rate_setting,
  // decoded start-up settings
  output logic      [31:0]       o_open_loop_startup_config,
  output logic                   o_parity_bit,
  output logic                   o_limit_use_runtime,
  output logic      [3:0]        o_openloop_current_thresh,
  output logic      [10:0]       o_openloop_sense_level_mv,
  output logic                   o_sense_level_valid,
  output logic      [6:0]        o_openloop_duty_cap_pct,
  output logic      [24:0]       o_ramp_rate_first_mhz,
  output logic      [24:0]       o_ramp_rate_second_mhz,
  output logic                   o_ramp_first_unlimited,
  output logic      [9:0]        o_loop_transfer_freq_hz,
  output logic                   o_auto_handoff,
  output logic                   o_handoff_use_thresh,
  output logic                   o_first_cycle_zero,
  output logic      [3:0]        o_first_cycle_rate_code,
  output logic      [3:0]        o_min_duty_code
);

  // the offset 84h needs at least eight address bits
  if (ADDR_W < 8)
  begin : g_addr_w_check
    $error("ADDR_W too narrow for the register offset");
  end

  olsc_lut_if lut ();

  olsc_pkg::olsc_cfg_s cfg_q;
  logic [31:0]         rdata_q;
  logic                rd_valid_q;
  logic [3:0]          thr_q;
  logic [10:0]         sense_q;
  logic                sense_ok_q;
  logic [6:0]          duty_q;
  logic [9:0]          hoff_q;
  logic [3:0]          fcyc_q;

  wire                 hit      = i_addr == ADDR_W'(`OLSC_CFG_OFFSET);
  wire                 wr_hit   = i_wr_en && hit;
  wire [31:0]          cfg_word = cfg_q;
  wire [31:0]          rd_word  = hit ? (cfg_word & `OLSC_WR_MASK)
                                      : 32'h0000_0000;
  wire [3:0]           thr_sel  = cfg_q.src_runtime
                                  ? i_runtime_current_limit
                                  : cfg_q.thresh;
  wire [10:0]          sense_mv = 11'(cfg_q.thresh * `OLSC_SENSE_STEP_MV);
  wire [3:0]           fcyc_sel = cfg_q.first_zero ? 4'h0
                                  : i_initial_cycle_rate_setting;

  function automatic logic [6:0] duty_of(input logic [2:0] c);
    case (c)
      3'h0:    duty_of = 7'h0A;
      3'h1:    duty_of = 7'h0F;
      3'h2:    duty_of = 7'h14;
      3'h3:    duty_of = 7'h19;
      3'h4:    duty_of = 7'h1E;
      3'h5:    duty_of = 7'h28;
      3'h6:    duty_of = 7'h32;
      default: duty_of = 7'h64;
    endcase
  endfunction : duty_of

  function automatic logic [9:0] hoff_of(input logic [4:0] c);
    case (c)
      5'h00:   hoff_of = 10'h001;
      5'h0B:   hoff_of = 10'h02D;
      5'h0C:   hoff_of = 10'h032;
      5'h0D:   hoff_of = 10'h037;
      5'h0E:   hoff_of = 10'h03C;
      5'h0F:   hoff_of = 10'h041;
      5'h10:   hoff_of = 10'h046;
      5'h11:   hoff_of = 10'h04B;
      5'h12:   hoff_of = 10'h050;
      5'h13:   hoff_of = 10'h055;
      5'h14:   hoff_of = 10'h05A;
      // codes 1..A step by 4 Hz, 15h and up by 50 Hz from 100 Hz
      default: hoff_of = (c < 5'h0B) ? {3'h0, c, 2'h0}
                         : 10'(10'h064 + (c - 5'h15) * 10'h032);
    endcase
  endfunction : hoff_of

  // reserved bits 1:0 never store, so they always read zero
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      cfg_q <= `OLSC_CFG_RESET;
    else if (wr_hit)
      cfg_q <= i_wdata & `OLSC_WR_MASK;
  end

  // a read in the write cycle returns the value from before the write
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_q    <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rdata_q    <= i_rd_en ? rd_word : 32'h0000_0000;
      rd_valid_q <= i_rd_en;
    end
  end

  // the threshold, sense level, duty, transfer frequency and first-cycle code decode is registered
  // to land in the same cycle as the table rates, one edge after the register changes; single-bit fields and min duty are not
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      thr_q      <= 4'h0;
      sense_q    <= 11'h000;
      sense_ok_q <= 1'b0;
      duty_q     <= 7'h0A;
      hoff_q     <= 10'h001;
      fcyc_q     <= 4'h0;
    end
    else
    begin
      thr_q      <= thr_sel;
      sense_q    <= sense_mv;
      sense_ok_q <= cfg_q.thresh != 4'h0;
      duty_q     <= duty_of(cfg_q.duty);
      hoff_q     <= hoff_of(cfg_q.handoff);
      fcyc_q     <= fcyc_sel;
    end
  end

  assign lut.code[0] = cfg_q.acc1;
  assign lut.code[1] = cfg_q.acc2;

  olsc_rate_lut u_rate_lut (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .lut   (lut.tab)
  );

  assign o_rdata                    = rdata_q;
  assign o_rd_valid                 = rd_valid_q;
  assign o_open_loop_startup_config = cfg_word;
  assign o_parity_bit               = cfg_q.parity;
  assign o_limit_use_runtime        = cfg_q.src_runtime;
  assign o_openloop_current_thresh  = thr_q;
  assign o_openloop_sense_level_mv  = sense_q;
  assign o_sense_level_valid        = sense_ok_q;
  assign o_openloop_duty_cap_pct    = duty_q;
  assign o_ramp_rate_first_mhz      = lut.rate[0];
  assign o_ramp_rate_second_mhz     = lut.rate[1];
  assign o_ramp_first_unlimited     = lut.rate[0] == `OLSC_NO_LIMIT_RATE;
  assign o_loop_transfer_freq_hz    = hoff_q;
  assign o_auto_handoff             = cfg_q.auto_handoff;
  assign o_handoff_use_thresh       = !cfg_q.auto_handoff;
  assign o_first_cycle_zero         = cfg_q.first_zero;
  assign o_first_cycle_rate_code    = fcyc_q;
  assign o_min_duty_code            = cfg_q.min_duty;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_write_read;
    wr_hit ##1 i_rd_en && hit |=>
      o_rd_valid && o_rdata == ($past(i_wdata, 2) & `OLSC_WR_MASK);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("register read does not return the written word");

  property p_unmapped;
    i_rd_en && !hit |=> o_rd_valid && o_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read did not return zero");

  property p_limit_src;
    ##1 o_openloop_current_thresh == ($past(cfg_q.src_runtime)
      ? $past(i_runtime_current_limit) : $past(cfg_q.thresh));
  endproperty
  a_limit_src: assert property (p_limit_src)
    else $error("current limit source not followed");

  property p_duty_max;
    cfg_q.duty == 3'h7 |=> o_openloop_duty_cap_pct == 7'h64;
  endproperty
  a_duty_max: assert property (p_duty_max)
    else $error("duty code 7 did not cap at 100 percent");

  property p_sense;
    cfg_q.thresh == 4'hF |=> o_openloop_sense_level_mv == 11'h5DC
      && o_sense_level_valid;
  endproperty
  a_sense: assert property (p_sense)
    else $error("threshold code F did not give 1.5 V");

  property p_sense_na;
    cfg_q.thresh == 4'h0 |=> !o_sense_level_valid;
  endproperty
  a_sense_na: assert property (p_sense_na)
    else $error("threshold code 0 shown as valid");

  property p_nolimit_flag;
    cfg_q.acc1 == `OLSC_NO_LIMIT_CODE |=> o_ramp_first_unlimited;
  endproperty
  a_nolimit_flag: assert property (p_nolimit_flag)
    else $error("no-limit first ramp code not flagged");

  property p_parity;
    wr_hit |=> o_parity_bit == $past(i_wdata[`OLSC_PARITY_BIT]);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity bit not stored");

  property p_hoff_ends;
    (cfg_q.handoff == 5'h1F |=> o_loop_transfer_freq_hz == 10'h258) and
    (cfg_q.handoff == 5'h0B |=> o_loop_transfer_freq_hz == 10'h02D);
  endproperty
  a_hoff_ends: assert property (p_hoff_ends)
    else $error("loop transfer frequency decode wrong");

  property p_auto;
    wr_hit |=> o_handoff_use_thresh == !$past(i_wdata[`OLSC_AUTO_BIT]);
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto handoff select not followed");

  property p_first_cycle;
    cfg_q.first_zero ##1 cfg_q.first_zero |-> o_first_cycle_rate_code == 4'h0;
  endproperty
  a_first_cycle: assert property (p_first_cycle)
    else $error("first cycle did not start from 0 Hz");

  c_write:   cover property (wr_hit);
  c_read:    cover property (i_rd_en && hit ##1 o_rd_valid);
  c_nolimit: cover property (o_ramp_first_unlimited);
  c_runtime: cover property (cfg_q.src_runtime && cfg_q.auto_handoff);

endmodule : olsc_top
`default_nettype wire

// >>> olsc_top_tb_top.sv
// olsc_top_tb_top: self-checking bench for the start-up configuration register.
// assumes: olsc_pkg, olsc_lut_if, olsc_rate_lut and olsc_top compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "olsc_regs.svh"
module olsc_top_tb_top;
  // ramp rates in milli-hertz per second, transfer frequencies in hertz
  localparam int ACC_MHZ [32] = '{5, 10, 25, 50, 100, 250, 500, 1000, 2500,
    5000, 7500, 10000, 12500, 15000, 20000, 30000, 40000, 50000, 60000, 75000,
    100000, 125000, 150000, 175000, 200000, 250000, 300000, 400000, 500000,
    750000, 1000000, 32767000};
  localparam int HOFF_HZ [32] = '{1, 4, 8, 12, 16, 20, 24, 28, 32, 36, 40, 45,
    50, 55, 60, 65, 70, 75, 80, 85, 90, 100, 150, 200, 250, 300, 350, 400, 450,
    500, 550, 600};
  localparam int DUTY_PCT [8] = '{10, 15, 20, 25, 30, 40, 50, 100};

  logic        i_clk;
  logic        i_rst;
  logic        i_wr_en;
  logic        i_rd_en;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic [31:0] o_rdata;
  logic        o_rd_valid;
  logic [3:0]  i_runtime_current_limit;
  logic [3:0]  i_initial_cycle_rate_setting;
  logic [31:0] o_open_loop_startup_config;
  logic        o_parity_bit;
  logic        o_limit_use_runtime;
  logic [3:0]  o_openloop_current_thresh;
  logic [10:0] o_openloop_sense_level_mv;
  logic        o_sense_level_valid;
  logic [6:0]  o_openloop_duty_cap_pct;
  logic [24:0] o_ramp_rate_first_mhz;
  logic [24:0] o_ramp_rate_second_mhz;
  logic        o_ramp_first_unlimited;
  logic [9:0]  o_loop_transfer_freq_hz;
  logic        o_auto_handoff;
  logic        o_handoff_use_thresh;
  logic        o_first_cycle_zero;
  logic [3:0]  o_first_cycle_rate_code;
  logic [3:0]  o_min_duty_code;
  int          fail_count;
  int          samples_checked;

  olsc_top #(.ADDR_W(8)) olsc_top_inst (
    .i_clk                        (i_clk),
    .i_rst                        (i_rst),
    .i_wr_en                      (i_wr_en),
    .i_rd_en                      (i_rd_en),
    .i_addr                       (i_addr),
    .i_wdata                      (i_wdata),
    .o_rdata                      (o_rdata),
    .o_rd_valid                   (o_rd_valid),
    .i_runtime_current_limit      (i_runtime_current_limit),
    .i_initial_cycle_rate_setting (i_initial_cycle_rate_setting),
    .o_open_loop_startup_config   (o_open_loop_startup_config),
    .o_parity_bit                 (o_parity_bit),
    .o_limit_use_runtime          (o_limit_use_runtime),
    .o_openloop_current_thresh    (o_openloop_current_thresh),
    .o_openloop_sense_level_mv    (o_openloop_sense_level_mv),
    .o_sense_level_valid          (o_sense_level_valid),
    .o_openloop_duty_cap_pct      (o_openloop_duty_cap_pct),
    .o_ramp_rate_first_mhz        (o_ramp_rate_first_mhz),
    .o_ramp_rate_second_mhz       (o_ramp_rate_second_mhz),
    .o_ramp_first_unlimited       (o_ramp_first_unlimited),
    .o_loop_transfer_freq_hz      (o_loop_transfer_freq_hz),
    .o_auto_handoff               (o_auto_handoff),
    .o_handoff_use_thresh         (o_handoff_use_thresh),
    .o_first_cycle_zero           (o_first_cycle_zero),
    .o_first_cycle_rate_code      (o_first_cycle_rate_code),
    .o_min_duty_code              (o_min_duty_code)
  );

  always #25 i_clk = ~i_clk;

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask : wr

  // read data stands for one cycle only, so it is taken right after the edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    chk("rd_valid", 32'h1, o_rd_valid);
    chk("rdata", exp, o_rdata);
  endtask : rd

  // write and read at one edge, then read alone: old word first, then new
  task automatic wr_rd(input logic [31:0] d, input logic [31:0] old);
    @(posedge i_clk);
    i_wr_en <= 1'b1;
    i_rd_en <= 1'b1;
    i_addr  <= `OLSC_CFG_OFFSET;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
    #1;
    chk("rdata_old", old, o_rdata);
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    chk("rd_valid", 32'h1, o_rd_valid);
    chk("rdata_new", d & 32'hFFFF_FFFC, o_rdata);
  endtask : wr_rd

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (3000) @(posedge i_clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    logic [4:0]  c;
    logic [31:0] w;
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_runtime_current_limit = 4'h0;
    i_initial_cycle_rate_setting = 4'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("rst_cfg", 32'h0, o_open_loop_startup_config);
    chk("rst_duty", 32'h0A, o_openloop_duty_cap_pct);
    chk("rst_valid", 32'h0, o_sense_level_valid);
    chk("rst_acc1", 32'h5, o_ramp_rate_first_mhz);
    chk("rst_freq", 32'h1, o_loop_transfer_freq_hz);
    chk("rst_thr", 32'h1, o_handoff_use_thresh);
    rd(`OLSC_CFG_OFFSET, 32'h0);
    // a write one address off must leave the register alone
    wr(8'h85, 32'hFFFF_FFFF);
    rd(`OLSC_CFG_OFFSET, 32'h0);
    rd(8'h00, 32'h0);
    for (int i = 0; i < 32; i++)
    begin
      c = 5'(i);
      @(posedge i_clk);
      i_runtime_current_limit <= ~c[3:0];
      i_initial_cycle_rate_setting <= c[3:0] ^ 4'hA;
      w = {c[2], c[4], c[2:0], c[3:0], c, ~c, c, c[0], c[1], c[3:0], 2'b11};
      wr(`OLSC_CFG_OFFSET, w);
      repeat (2) @(posedge i_clk);
      #1;
      chk("cfg", w & 32'hFFFF_FFFC, o_open_loop_startup_config);
      chk("parity", c[2], o_parity_bit);
      chk("src", c[4], o_limit_use_runtime);
      chk("thresh", c[4] ? 4'(~c[3:0]) : c[3:0],
          o_openloop_current_thresh);
      chk("sense", 32'(c[3:0]) * 100, o_openloop_sense_level_mv);
      chk("sense_ok", c[3:0] != 4'h0, o_sense_level_valid);
      chk("duty", DUTY_PCT[c[2:0]], o_openloop_duty_cap_pct);
      chk("acc1", ACC_MHZ[i], o_ramp_rate_first_mhz);
      chk("unlim", c == 5'h1F, o_ramp_first_unlimited);
      chk("acc2", ACC_MHZ[31 - i], o_ramp_rate_second_mhz);
      chk("freq", HOFF_HZ[i], o_loop_transfer_freq_hz);
      chk("auto", c[0], o_auto_handoff);
      chk("use_thr", !c[0], o_handoff_use_thresh);
      chk("fzero", c[1], o_first_cycle_zero);
      chk("fcode", c[1] ? 4'h0 : c[3:0] ^ 4'hA, o_first_cycle_rate_code);
      chk("mduty", c[3:0], o_min_duty_code);
      rd(`OLSC_CFG_OFFSET, w & 32'hFFFF_FFFC);
    end
    wr_rd(32'hA5C3_96F3, w & 32'hFFFF_FFFC);
    // a second reset in mid-run must clear the stored word again
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("rst2_cfg", 32'h0, o_open_loop_startup_config);
    chk("rst2_rdv", 32'h0, o_rd_valid);
    chk("rst2_acc2", 32'h5, o_ramp_rate_second_mhz);
    summarize();
  end
endmodule : olsc_top_tb_top
`default_nettype wire
